// ==== flag_ctrl_pkg.sv ====
package flag_ctrl_pkg;

   // Clock and time base.
   localparam longint CLK_HZ        = 125_000_000;
   localparam longint MINUTE_S      = 60;
   localparam longint MINUTE_CYCLES = MINUTE_S * CLK_HZ;
   localparam int     DAY_MINUTES   = 1440;

   // Flags, nesting and call limits.
   localparam int NUM_FLAGS = 10;
   localparam int OUT_FLAG  = 0;
   localparam int IPD_FLAG  = 9;
   localparam int MAX_NEST  = 9;
   localparam int MAX_CALL  = 7;

   // Register byte offsets.
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_MANUAL   = 8'h04;
   localparam logic [7:0] REG_INSTR    = 8'h08;
   localparam logic [7:0] REG_CASE_REF = 8'h0c;
   localparam logic [7:0] REG_INTERVAL = 8'h10;
   localparam logic [7:0] REG_STATUS   = 8'h14;
   localparam logic [7:0] REG_CALL     = 8'h18;

   // Field positions.
   localparam int CTRL_START_BIT = 0;
   localparam int INSTR_KIND_LSB = 0;
   localparam int INSTR_CMD_LSB  = 4;
   localparam int INSTR_COND_BIT = 11;
   localparam int INSTR_FIX_LSB  = 16;
   localparam int IVL_LEN_LSB    = 0;
   localparam int IVL_OFS_LSB    = 16;
   localparam int ST_SKIP_BIT    = 10;
   localparam int ST_HALT_BIT    = 11;
   localparam int ST_REJECT_BIT  = 12;
   localparam int ST_TIME_BIT    = 13;
   localparam int ST_LEVEL_LSB   = 16;
   localparam int ST_SUB_LSB     = 20;

   // Reset values.
   localparam logic [9:0]  FLAGS_RST    = 10'h000;
   localparam logic [31:0] INTERVAL_RST = 32'h0000_0000;
   localparam logic [31:0] CASE_RST     = 32'h0000_0000;

   // Command codes.
   localparam logic [6:0] CMD_GOTO_END = 7'h00;
   localparam logic [6:0] CMD_SET_F0   = 7'h0a;
   localparam logic [6:0] CMD_CLR_F0   = 7'h14;
   localparam logic [6:0] CMD_THEN_DO  = 7'h1e;
   localparam logic [6:0] CMD_CALL_LO  = 7'h01;
   localparam logic [6:0] CMD_CALL_MID = 7'h09;
   localparam logic [6:0] CMD_CALL_HI0 = 7'h4f;
   localparam logic [6:0] CMD_CALL_HI1 = 7'h63;
   localparam logic [6:0] SUB_PORT7    = 7'h61;
   localparam logic [6:0] SUB_PORT8    = 7'h62;

   typedef enum logic [3:0] {
      K_NOP, K_COND, K_IF_TIME, K_CASE_BEGIN, K_CASE_TEST,
      K_LOOP, K_ELSE, K_END, K_RETURN, K_OUTPUT
   } instr_kind_t;

endpackage

// ==== interval_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
   parameter longint MIN_CYCLES = flag_ctrl_pkg::MINUTE_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [10:0] interval_min,
   input  wire logic [10:0] offset_min,
   output logic             time_hit
);
   import flag_ctrl_pkg::*;

   logic [32:0] div_cnt;
   logic [10:0] minute;
   logic [10:0] phase;
   logic        armed;

   // One-cycle enable once per minute; each later step runs on it.
   wire tick       = (div_cnt == 33'(MIN_CYCLES - 1));
   wire [10:0] nxt = (minute == 11'(DAY_MINUTES - 1)) ? 11'h000 : minute + 11'h001;
   wire at_ofs     = (nxt == offset_min);
   wire phase_end  = armed && (interval_min != 11'h000) && (phase + 11'h001 == interval_min);

   // Minute divider.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) div_cnt <= 33'h0_0000_0000;
      else if (tick) div_cnt <= 33'h0_0000_0000;
      else div_cnt <= div_cnt + 33'h0_0000_0001;
   end

   // Midnight always fires and restarts the phase, so a short last interval results.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         minute   <= 11'h000;
         phase    <= 11'h000;
         armed    <= 1'b1;
         time_hit <= 1'b0;
      end else if (tick) begin
         minute <= nxt;
         if (nxt == 11'h000 || at_ofs || phase_end) begin
            time_hit <= (nxt == 11'h000) || at_ofs || phase_end;
            phase    <= 11'h000;
            armed    <= at_ofs || (offset_min == 11'h000);
         end else begin
            time_hit <= 1'b0;
            phase    <= phase + 11'h001;
         end
      end
   end

   if (MIN_CYCLES < 2) begin : g_chk
      $error("interval_timer needs at least two cycles per minute");
   end
endmodule
`default_nettype wire

// ==== nest_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none
module nest_tracker
   import flag_ctrl_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       clear,
   input  wire logic       push,
   input  wire logic       push_else,
   input  wire logic       pop,
   input  wire logic       call,
   input  wire logic       ret,
   output logic [3:0]      depth,
   output logic [3:0]      level,
   output logic            top_else,
   output logic [2:0]      sub_depth
);
   logic [3:0] else_cnt;
   logic [8:0] else_bits;
   logic [3:0] sv_depth [MAX_CALL];
   logic [3:0] sv_cnt   [MAX_CALL];
   logic [8:0] sv_bits  [MAX_CALL];

   // Else levels count toward the limit but close with their own frame.
   assign level    = depth + else_cnt;
   assign top_else = (depth != 4'h0) && else_bits[4'(depth - 4'h1)];
   wire   [3:0] top = 4'(depth - 4'h1);

   // Frame stack; a call saves it and starts at zero, a return restores it.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         depth <= 4'h0; else_cnt <= 4'h0; else_bits <= 9'h000; sub_depth <= 3'h0;
      end else if (clear) begin
         depth <= 4'h0; else_cnt <= 4'h0; else_bits <= 9'h000; sub_depth <= 3'h0;
      end else if (call) begin
         sv_depth[sub_depth] <= depth;
         sv_cnt[sub_depth]   <= else_cnt;
         sv_bits[sub_depth]  <= else_bits;
         depth <= 4'h0; else_cnt <= 4'h0; else_bits <= 9'h000;
         sub_depth <= sub_depth + 3'h1;
      end else if (ret) begin
         depth     <= sv_depth[3'(sub_depth - 3'h1)];
         else_cnt  <= sv_cnt[3'(sub_depth - 3'h1)];
         else_bits <= sv_bits[3'(sub_depth - 3'h1)];
         sub_depth <= sub_depth - 3'h1;
      end else if (push) begin
         else_bits[depth] <= 1'b0;
         depth <= depth + 4'h1;
      end else if (push_else) begin
         else_bits[top] <= 1'b1;
         else_cnt <= else_cnt + 4'h1;
      end else if (pop) begin
         if (top_else) else_cnt <= else_cnt - 4'h1;
         else_bits[top] <= 1'b0;
         depth <= top;
      end
   end
endmodule
`default_nettype wire

// ==== program_flag_branch_control.sv ====
// How it works
// - Ten flags: 0 gates storage, 9 stops sampling, 1-8 are free.
// - Starting a table drives flags 0 and 9 low.
// - Flags 1-8 keep their value across tables.
// - A false test aimed at raising flag 0 or 9 drives it low.
// - A false test aimed at flags 1-8 leaves them alone.
// - Output instructions store results only while flag 0 is high.
// - Interval test fires at midnight plus offset and one interval later; each interval only with offset 0.
// - Short last interval; midnight always fires and resynchronises.
// - While flag 9 is high, intermediate sampling is suspended.
// - True code 0 ends the table; codes 1-9, 79-99 call subroutines.
// - Rising control ports 7 and 8 call subroutines 97 and 98.
// - Code 30 runs the block when true, else skips to else or end.
// - A false nested test skips everything up to its own end.
// - Case tests run the first command whose fixed value exceeds the reference.
// - Branch and loop nesting stops at nine levels, else counting one.
// - Calls have their own depth of seven; nesting restarts inside them.
// - Sampling happens on output execution; storing zeroes the accumulators.
`timescale 1ns/1ps
`default_nettype none
module program_flag_branch_control #(
   parameter longint MIN_CYCLES = flag_ctrl_pkg::MINUTE_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        port7_in,
   input  wire logic        port8_in,
   output logic [9:0]       flags_out,
   output logic             store_strobe,
   output logic             sample_strobe,
   output logic             call_strobe,
   output logic [6:0]       call_num,
   output logic             table_end
);
   import flag_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Byte-lane merge for registers that keep written data.
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction

   // True for command codes that call a numbered subroutine.
   function automatic logic cmd_is_call(input logic [6:0] c);
      return ((c >= CMD_CALL_LO) && (c <= CMD_CALL_MID)) ||
             ((c >= CMD_CALL_HI0) && (c <= CMD_CALL_HI1));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   logic [9:0]  flags;
   logic [31:0] case_ref;
   logic [31:0] interval_reg;
   logic [3:0]  skip_level;
   logic        halted;
   logic        rejected;
   logic        p7_s1, p7_s2, p7_d;
   logic        p8_s1, p8_s2, p8_d;
   logic        pend7, pend8;
   logic [2:0]  sub_depth;
   logic [3:0]  depth;
   logic [3:0]  level;
   logic        top_else;
   logic        time_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then the transfer completes.

   wire wr        = avs_write && !avs_waitrequest && (avs_byteenable != 4'h0);
   wire wr_ctrl   = wr && (avs_address == REG_CTRL);
   wire wr_manual = wr && (avs_address == REG_MANUAL);
   wire wr_instr  = wr && (avs_address == REG_INSTR);
   wire wr_case   = wr && (avs_address == REG_CASE_REF);
   wire wr_ivl    = wr && (avs_address == REG_INTERVAL);

   // Waitrequest drops for exactly one cycle per request.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) avs_waitrequest <= 1'b1;
      else avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   // Read data are captured in the wait cycle and stand through the completing edge.
   wire [31:0] status_word = {9'h000, sub_depth, level, 2'h0, time_hit, rejected,
                              halted, (skip_level != 4'h0), flags};
   wire [31:0] read_mux =
      (avs_address == REG_MANUAL)   ? {22'h00_0000, flags} :
      (avs_address == REG_CASE_REF) ? case_ref :
      (avs_address == REG_INTERVAL) ? interval_reg :
      (avs_address == REG_STATUS)   ? status_word :
      (avs_address == REG_CALL)     ? {22'h00_0000, sub_depth, call_num} :
                                      32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest) avs_readdata <= read_mux;
   end

   // Stored operands: case reference and interval settings.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         case_ref     <= CASE_RST;
         interval_reg <= INTERVAL_RST;
      end else begin
         if (wr_case) case_ref <= be_merge(case_ref, avs_writedata, avs_byteenable);
         if (wr_ivl) interval_reg <= be_merge(interval_reg, avs_writedata, avs_byteenable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction decode.

   wire              table_start = wr_ctrl && avs_writedata[CTRL_START_BIT];
   wire instr_kind_t kind        = instr_kind_t'(avs_writedata[INSTR_KIND_LSB +: 4]);
   wire [6:0]        cmd         = avs_writedata[INSTR_CMD_LSB +: 7];
   wire [15:0]       fix_val     = avs_writedata[INSTR_FIX_LSB +: 16];
   wire              instr_go    = wr_instr && !halted;

   // Case compares the begin-case reference against the fixed value.
   wire case_true = $signed(case_ref) < $signed({{16{fix_val[15]}}, fix_val});
   wire cond      = (kind == K_IF_TIME)   ? time_hit :
                    (kind == K_CASE_TEST) ? case_true :
                                            avs_writedata[INSTR_COND_BIT];
   wire is_test   = (kind == K_COND) || (kind == K_IF_TIME) || (kind == K_CASE_TEST);
   wire is_then   = ((kind == K_COND) || (kind == K_IF_TIME)) && (cmd == CMD_THEN_DO);
   wire opens     = is_then || (kind == K_LOOP) || (kind == K_CASE_BEGIN);
   wire running   = (skip_level == 4'h0);
   wire room      = (level < 4'(MAX_NEST));
   wire call_room = (sub_depth < 3'(MAX_CALL));

   // Frame bookkeeping happens while skipping too, so ends pair correctly.
   wire over_nest = instr_go && room == 1'b0 &&
                    (opens || (kind == K_ELSE && running && depth != 4'h0));
   wire push      = instr_go && opens && room;
   wire push_else = instr_go && (kind == K_ELSE) && room && (depth != 4'h0) && !top_else &&
                    (running || skip_level == depth);
   wire pop       = instr_go && (kind == K_END) && (depth != 4'h0);
   wire act       = instr_go && running && is_test;
   wire ret       = instr_go && running && (kind == K_RETURN) && (sub_depth != 3'h0);

   // Calls from the program take precedence; port calls wait for a free cycle.
   wire prog_call = act && cond && cmd_is_call(cmd);
   wire port_slot = !wr_instr && !table_start && !halted;
   wire take7     = port_slot && pend7;
   wire take8     = port_slot && pend8 && !pend7;
   wire want_call = prog_call || take7 || take8;
   wire do_call   = want_call && call_room;
   wire [6:0] next_call_num = prog_call ? cmd : (take7 ? SUB_PORT7 : SUB_PORT8);

   ////////////////////////////////////////////////////////////////////////////////
   // Nesting, subroutine depth and the interval clock.

   nest_tracker u_nest (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .clear     (table_start),
      .push      (push),
      .push_else (push_else),
      .pop       (pop),
      .call      (do_call),
      .ret       (ret),
      .depth     (depth),
      .level     (level),
      .top_else  (top_else),
      .sub_depth (sub_depth)
   );

   interval_timer #(.MIN_CYCLES(MIN_CYCLES)) u_timer (
      .core_clk     (core_clk),
      .rst_b        (rst_b),
      .interval_min (interval_reg[IVL_LEN_LSB +: 11]),
      .offset_min   (interval_reg[IVL_OFS_LSB +: 11]),
      .time_hit     (time_hit)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Skip level: nonzero means instructions are passed over until its end.

   wire [3:0] next_skip_level =
      table_start                                      ? 4'h0 :
      (push && running && is_then && !cond)            ? depth + 4'h1 :
      (push_else && running)                           ? depth :
      push_else                                        ? 4'h0 :
      (pop && skip_level == depth)                     ? 4'h0 :
      (act && kind == K_CASE_TEST && cond)             ? depth :
      do_call || ret                                   ? 4'h0 :
                                                         skip_level;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) skip_level <= 4'h0;
      else skip_level <= next_skip_level;
   end

   // Code 0 ends the table; nothing more runs until the next table start.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) halted <= 1'b0;
      else if (table_start) halted <= 1'b0;
      else if (act && cond && cmd == CMD_GOTO_END) halted <= 1'b1;
   end

   // Sticky reject flag, cleared only by a table start unless a reject coincides.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) rejected <= 1'b0;
      else if (over_nest || (want_call && !call_room)) rejected <= 1'b1;
      else if (table_start) rejected <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flags.

   wire  [9:0] next_flags;
   for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      localparam bit DEDICATED = (i == OUT_FLAG) || (i == IPD_FLAG);
      wire set_hit = act && cond && (cmd == 7'(CMD_SET_F0 + i));
      wire clr_hit = act && cond && (cmd == 7'(CMD_CLR_F0 + i));
      // A failed raise drops only the dedicated flags.
      wire fail_hit = act && !cond && (cmd == 7'(CMD_SET_F0 + i)) && DEDICATED;
      wire tog_hit  = wr_manual && !DEDICATED && avs_writedata[i];
      assign next_flags[i] =
         (table_start && DEDICATED) ? 1'b0 :
         set_hit                    ? 1'b1 :
         (clr_hit || fail_hit)      ? 1'b0 :
         tog_hit                    ? !flags[i] :
                                      flags[i];
   end

   // Ten flags, all low out of reset.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) flags <= FLAGS_RST;
      else flags <= next_flags;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) flags_out <= FLAGS_RST;
      else flags_out <= next_flags;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output processing strobes.

   // Sampling follows each executed output instruction while flag 9 is low, never data updates.
   wire out_go = instr_go && running && (kind == K_OUTPUT);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         store_strobe  <= 1'b0;
         sample_strobe <= 1'b0;
      end else begin
         store_strobe  <= out_go && flags[OUT_FLAG];
         sample_strobe <= out_go && !flags[IPD_FLAG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control port inputs: two-flop synchronisers, then edge detection.

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         p7_s1 <= 1'b0; p7_s2 <= 1'b0; p7_d <= 1'b0;
         p8_s1 <= 1'b0; p8_s2 <= 1'b0; p8_d <= 1'b0;
      end else begin
         p7_s1 <= port7_in; p7_s2 <= p7_s1; p7_d <= p7_s2;
         p8_s1 <= port8_in; p8_s2 <= p8_s1; p8_d <= p8_s2;
      end
   end

   // A rising port is held pending until a call slot is free; a new edge wins over service.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend7 <= 1'b0;
         pend8 <= 1'b0;
      end else begin
         if (p7_s2 && !p7_d) pend7 <= 1'b1;
         else if (take7) pend7 <= 1'b0;
         if (p8_s2 && !p8_d) pend8 <= 1'b1;
         else if (take8) pend8 <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Call and table-end outputs.

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         call_strobe <= 1'b0;
         call_num    <= 7'h00;
         table_end   <= 1'b0;
      end else begin
         call_strobe <= do_call;
         if (do_call) call_num <= next_call_num;
         table_end <= (halted && !table_start) || (act && cond && cmd == CMD_GOTO_END);
      end
   end

   if (MIN_CYCLES < 2) begin : g_chk
      $error("MIN_CYCLES must be at least 2");
   end
endmodule
`default_nettype wire

// ==== flag_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module flag_chk #(
   parameter longint MIN_CYCLES = 4
) (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        port7_in,
   input wire logic [9:0]  flags_out,
   input wire logic        store_strobe,
   input wire logic        sample_strobe,
   input wire logic        call_strobe,
   input wire logic [6:0]  call_num,
   input wire logic        table_end
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Completed writes, the table start and the manual toggle mask.
   wire       done_wr = avs_write && !avs_waitrequest;
   wire       start   = done_wr && avs_address == 8'h00 && avs_writedata[0];
   wire [9:0] tgl     = avs_writedata[9:0] & 10'h1fe;
   ////////////////////////////////////////////////////////////
   a_ack_once: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad wait timing");
   a_store_gate: assert property (store_strobe |-> flags_out[0])
      else $error("store without output flag");
   a_sample_gate: assert property (sample_strobe |-> !flags_out[9])
      else $error("sample while disabled");
   a_start_clear: assert property (start |=> flags_out[0] == 1'b0 && flags_out[9] == 1'b0)
      else $error("start left flag 0 or 9");
   a_user_keep: assert property (start |=> flags_out[8:1] == $past(flags_out[8:1]))
      else $error("start changed user flags");
   a_manual_tgl: assert property (done_wr && avs_address == 8'h04
      |=> flags_out == ($past(flags_out) ^ $past(tgl))) else $error("bad toggle");
   a_call_code: assert property (call_strobe |->
      call_num inside {[7'd1:7'd9], [7'd79:7'd99]}) else $error("bad call number");
   a_call_hold: assert property ($changed(call_num) |-> call_strobe)
      else $error("call number moved");
   a_end_hold: assert property (table_end && !start |=> table_end)
      else $error("table end dropped");
   a_port_call: assert property ($rose(port7_in) |->
      ##[3:40] call_strobe && call_num == 7'h61) else $error("port call missing");
   cover property (store_strobe);
   cover property (call_strobe && call_num == 7'h62);
   cover property (table_end);
endmodule
bind program_flag_branch_control flag_chk #(.MIN_CYCLES(MIN_CYCLES)) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .port7_in(port7_in), .flags_out(flags_out), .store_strobe(store_strobe),
   .sample_strobe(sample_strobe), .call_strobe(call_strobe), .call_num(call_num),
   .table_end(table_end));
`default_nettype wire

// ==== prog_entry.sv ====
`timescale 1ns/1ps
`default_nettype none
module prog_entry (
   input wire logic [3:0]  kind,
   input wire logic [6:0]  cmd,
   input wire logic        cond,
   input wire logic [15:0] fix,
   output logic [31:0]     word
);
   // Packs one stored table entry into the instruction word.
   assign word = {fix, 4'h0, cond, cmd, kind};
endmodule
`default_nettype wire

// ==== program_flag_branch_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module program_flag_branch_control_bench;
   import flag_ctrl_pkg::*;
   logic        core_clk, rst_b, avs_read, avs_write, avs_waitrequest, port7_in, port8_in, pt;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, pw, r;
   logic [3:0]  avs_byteenable, pk;
   logic [6:0]  pc;
   logic [15:0] pf;
   logic [9:0]  fl;
   logic        ss, sm, te;
   logic [63:0] q[$];
   int          failures, n_compared, seed, ns;
   program_flag_branch_control #(.MIN_CYCLES(8)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port7_in(port7_in),
      .port8_in(port8_in), .flags_out(), .store_strobe(ss), .sample_strobe(sm),
      .call_strobe(), .call_num(), .table_end(te));
   prog_entry u_pe (.kind(pk), .cmd(pc), .cond(pt), .fix(pf), .word(pw));
   ////////////////////////////////////////////////////////////
   // Comparison, bus cycles and the closing task.
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("wrong value at %0t: read %h, expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_write     <= w;
      avs_read      <= !w;
      avs_address   <= a;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      q.push_back({m, e});
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic rf();
      rd(REG_MANUAL, 32'hffff_ffff, {22'h0, fl});
   endtask
   task automatic ins(input logic [3:0] k, input int c, input logic t, input int f = 0);
      pk = k;
      pc = c[6:0];
      pt = t;
      pf = f[15:0];
      #1;
      bus(1'b1, REG_INSTR, pw);
   endtask
   task end_sim;
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Read answers are compared against the oldest note.
   always @(posedge core_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         chk(avs_readdata & q[0][63:32], q[0][31:0]);
         void'(q.pop_front());
      end
   end
   // Store strobes count two and sample strobes one as they appear.
   always @(posedge core_clk) ns += 2 * ss + sm;
   // Clock and watchdog.
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      failures++;
      end_sim();
   end
   // Main sequence.
   initial begin
      {rst_b, avs_read, avs_write, port7_in, port8_in, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      seed = 32'hc8b1_854b;
      fl = 10'h000;
      failures = 0;
      n_compared = 0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      rf();
      for (int i = 0; i < 10; i++) ins(K_COND, 10 + i, 1'b1);
      fl = 10'h3ff;
      rf();
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      fl = 10'h1fe;
      rf();
      for (int i = 0; i < 10; i += 9) begin
         ins(K_COND, 10 + i, 1'b1);
         ins((i == 0) ? K_IF_TIME : K_COND, 10 + i, 1'b0);
      end
      ins(K_COND, 12, 1'b0);
      rf();
      repeat (3) begin
         r = $random(seed);
         bus(1'b1, REG_MANUAL, r);
         fl ^= r[9:0] & 10'h1fe;
         rf();
      end
      bus(1'b1, REG_MANUAL, {22'h0, fl});
      ins(K_COND, 30, 1'b0);
      ins(K_COND, 11, 1'b1);
      ins(K_ELSE, 0, 1'b0);
      ins(K_COND, 12, 1'b1);
      ins(K_END, 0, 1'b0);
      fl = 10'h004;
      rf();
      ins(K_COND, 30, 1'b1);
      ins(K_COND, 30, 1'b0);
      ins(K_COND, 13, 1'b1);
      ins(K_END, 0, 1'b0);
      ins(K_COND, 14, 1'b1);
      ins(K_END, 0, 1'b0);
      fl = 10'h014;
      rf();
      repeat (10) ins(K_COND, 30, 1'b1);
      rd(REG_STATUS, 32'h000f_1000, 32'h0009_1000);
      repeat (9) ins(K_END, 0, 1'b0);
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      ins(K_COND, 30, 1'b1);
      ins(K_ELSE, 0, 1'b0);
      rd(REG_STATUS, 32'h000f_1000, 32'h0002_0000);
      ins(K_END, 0, 1'b0);
      bus(1'b1, REG_CASE_REF, 32'h0000_0005);
      ins(K_CASE_BEGIN, 0, 1'b0);
      ins(K_CASE_TEST, 15, 1'b1, 3);
      ins(K_CASE_TEST, 16, 1'b1, 9);
      ins(K_CASE_TEST, 17, 1'b1, 20);
      ins(K_END, 0, 1'b0);
      fl = 10'h054;
      rf();
      for (int c = 1; c < 100; c += (c == 9) ? 70 : 8) begin
         ins(K_COND, c, 1'b1);
         rd(REG_CALL, 32'h0000_03ff, {22'h0, 3'd1, c[6:0]});
         ins(K_RETURN, 0, 1'b0);
      end
      ins(K_COND, 30, 1'b1);
      repeat (8) ins(K_COND, 5, 1'b1);
      rd(REG_STATUS, 32'h007f_1000, 32'h0070_1000);
      repeat (7) ins(K_RETURN, 0, 1'b0);
      ins(K_END, 0, 1'b0);
      for (int p = 0; p < 2; p++) begin
         port7_in <= (p == 0);
         port8_in <= (p == 1);
         repeat (12) @(posedge core_clk);
         rd(REG_CALL, 32'h0000_03ff, 32'h0000_00e1 + p);
         ins(K_RETURN, 0, 1'b0);
      end
      {port7_in, port8_in} <= 2'b00;
      ins(K_COND, 10, 1'b1);
      ins(K_OUTPUT, 0, 1'b0);
      ins(K_COND, 19, 1'b1);
      ins(K_OUTPUT, 0, 1'b0);
      ins(K_COND, 0, 1'b1);
      ins(K_COND, 18, 1'b1);
      rd(REG_STATUS, 32'h0000_0bff, {20'h0, 2'b10, 10'h255});
      bus(1'b1, REG_INTERVAL, 32'h0003_0002);
      rd(REG_INTERVAL, 32'h07ff_07ff, 32'h0003_0002);
      rd(8'h1c, 32'hffff_ffff, 32'h0000_0000);
      repeat (5) @(posedge core_clk);
      chk(ns, 32'd5);
      chk(te, 32'd1);
      end_sim();
   end
endmodule
`default_nettype wire
